// ---- design/srasl_if.sv ----
`timescale 1ns/1ns
interface srasl_if;
  logic scl_o;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic sda_mst_o;
  logic sda_mst_oe;
  wire logic scl;
  wire logic sda;
  assign scl = scl_o;
  assign sda = !((sda_dev_oe && !sda_dev_o) || (sda_mst_oe && !sda_mst_o));
  modport dev (
    input scl,
    input sda,
    output sda_dev_o,
    output sda_dev_oe
  );
  modport mst (
    input scl,
    input sda,
    output scl_o,
    output sda_mst_o,
    output sda_mst_oe
  );
endinterface

// ---- design/srasl_master.sv ----
`timescale 1ns/1ns
module srasl_master #(
  parameter int HALF = srasl_pkg::HALF_CYC
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  srasl_if.mst bus,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic cmd_read_i,
  input wire logic [6:0] cmd_dev_i,
  input wire logic [7:0] cmd_reg_i,
  input wire logic [7:0] cmd_data_i,
  output logic rsp_valid_o,
  output logic [7:0] rsp_data_o,
  output logic rsp_nack_o
);
  typedef enum {M_IDLE, M_START, M_BIT, M_STOP} srasl_mstate_t;
  srasl_mstate_t state;
  logic [15:0] div;
  logic [1:0] phase;
  logic [1:0] sda_sy;
  logic [8:0] sh;
  logic [3:0] bitn;
  logic [1:0] byten;
  logic rd;
  logic [6:0] dev;
  logic [7:0] regb;
  logic [7:0] datb;
  logic nack;
  logic tick;
  assign tick = div == 16'(HALF - 1);
  assign cmd_ready_o = state == M_IDLE;
  assign bus.sda_mst_o = 1'b0;
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      sda_sy <= 2'h3;
    end else begin
      sda_sy <= {sda_sy[0], bus.sda};
    end
  end
  always_ff @(posedge clk_i) begin
    if (!resetn_i || state == M_IDLE || tick) begin
      div <= 16'h0000;
    end else begin
      div <= div + 16'h0001;
    end
  end
  // byte sequence: write = dev, reg, data; read = dev+w, reg, rstart,
  // dev+r, one data byte nacked
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state <= M_IDLE;
      bus.scl_o <= 1'b1;
      bus.sda_mst_oe <= 1'b0;
      phase <= 2'h0;
      sh <= 9'h1FF;
      bitn <= 4'h0;
      byten <= 2'h0;
      rd <= 1'b0;
      dev <= 7'h00;
      regb <= 8'h00;
      datb <= 8'h00;
      nack <= 1'b0;
      rsp_valid_o <= 1'b0;
      rsp_data_o <= 8'h00;
      rsp_nack_o <= 1'b0;
    end else begin
      rsp_valid_o <= 1'b0;
      unique case (state)
        M_IDLE: begin
          if (cmd_valid_i) begin
            rd <= cmd_read_i;
            dev <= cmd_dev_i;
            regb <= cmd_reg_i;
            datb <= cmd_data_i;
            byten <= 2'h0;
            nack <= 1'b0;
            phase <= 2'h0;
            state <= M_START;
          end
        end
        M_START: if (tick) begin
          phase <= phase + 2'h1;
          if (phase == 2'h0) begin
            // a repeated start lowers the clock first so the slave lets go
            if (byten == 2'h3) begin
              bus.scl_o <= 1'b0;
            end
          end else if (phase == 2'h1) begin
            bus.sda_mst_oe <= 1'b0;
          end else if (phase == 2'h2) begin
            bus.scl_o <= 1'b1;
          end else begin
            bus.sda_mst_oe <= 1'b1;
            sh <= (byten == 2'h3) ? {dev, 1'b1, 1'b1} : {dev, 1'b0, 1'b1};
            bitn <= 4'h0;
            phase <= 2'h0;
            state <= M_BIT;
          end
        end
        M_BIT: if (tick) begin
          phase <= phase + 2'h1;
          unique case (phase)
            2'h0: begin
              bus.scl_o <= 1'b0;
            end
            2'h1: begin
              bus.sda_mst_oe <= !sh[8];
            end
            2'h2: begin
              bus.scl_o <= 1'b1;
            end
            default: begin
              sh <= {sh[7:0], sda_sy[1]};
              bitn <= bitn + 4'h1;
              phase <= 2'h0;
              if (bitn == 4'h8) begin
                if (sda_sy[1] && !(rd && byten == 2'h2)) nack <= 1'b1;
                if (rd && byten == 2'h2) begin
                  rsp_data_o <= sh[7:0];
                  rsp_nack_o <= nack;
                  rsp_valid_o <= 1'b1;
                  state <= M_STOP;
                end else if (sda_sy[1]) begin
                  state <= M_STOP;
                end else if (rd && byten == 2'h1) begin
                  byten <= 2'h3;
                  state <= M_START;
                end else if (!rd && byten == 2'h2) begin
                  rsp_nack_o <= 1'b0;
                  rsp_valid_o <= 1'b1;
                  state <= M_STOP;
                end else begin
                  byten <= (byten == 2'h3) ? 2'h2 : byten + 2'h1;
                  bitn <= 4'h0;
                  // read data byte: release, then nack the only byte
                  sh <= (byten == 2'h3) ? 9'h1FF :
                    (byten == 2'h0) ? {regb, 1'b1} : {datb, 1'b1};
                end
              end
            end
          endcase
        end
        M_STOP: if (tick) begin
          phase <= phase + 2'h1;
          if (phase == 2'h0) begin
            bus.scl_o <= 1'b0;
          end else if (phase == 2'h1) begin
            bus.sda_mst_oe <= 1'b1;
          end else if (phase == 2'h2) begin
            bus.scl_o <= 1'b1;
          end else begin
            bus.sda_mst_oe <= 1'b0;
            if (nack) begin
              rsp_nack_o <= 1'b1;
              rsp_valid_o <= 1'b1;
            end
            state <= M_IDLE;
          end
        end
      endcase
    end
  end
endmodule // srasl_master

// ---- design/srasl_pkg.sv ----
package srasl_pkg;
  // serial clock ceiling and spike width
  localparam int BUS_MAX_HZ = 1000000;
  localparam int CLK_HZ = 20000000;
  localparam int SPIKE_NS = 50;
  localparam int CLK_NS = 50;
  // spike filter: a level must stand on samples spanning more than a spike
  localparam int FILT_CYC = (SPIKE_NS + CLK_NS - 1) / CLK_NS + 2;
  // master clock divider: quarter period of the serial clock in cycles
  localparam int HALF_CYC = CLK_HZ / (2 * BUS_MAX_HZ) * 4;
  localparam logic [5:0] DEV_ADDR_HI = 6'h1D;
  localparam int ADDR_W = 8;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam int BUF_DEPTH = 2;
endpackage

// ---- design/srasl_slave.sv ----
// Contract
// - port works up to 1 MHz clock
// - filter spikes of 50 ns or less
// - slave only; clock is input only
// - drive zero low, release for one
// - data changes only while clock low
// - receiver samples bit on rising clock
// - data released while bus idle
// - start condition begins address reception
// - matching address acknowledged, else passive
// - write: register address then data bytes
// - read from last address, then increment
// - receiver acknowledges every byte; slave nacks write data bytes while its write buffer is full
// - stop abandons transfer, returns idle
// - repeated start restarts address reception
// - master withholds final read acknowledge
// - address 011101, select bit, direction
`timescale 1ns/1ns
module srasl_slave #(
  parameter int FILT = srasl_pkg::FILT_CYC
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  srasl_if.dev bus,
  input wire logic address_select_bit_i,
  output logic wr_valid_o,
  input wire logic wr_ready_i,
  output logic [7:0] wr_addr_o,
  output logic [7:0] wr_data_o,
  output logic [7:0] rd_addr_o,
  input wire logic [7:0] rd_data_i
);
  typedef enum {S_IDLE, S_ADDR, S_REG, S_WDATA, S_RDATA, S_MACK,
    S_SKIP} srasl_state_t;
  srasl_state_t state;
  logic [1:0] scl_sy;
  logic [1:0] sda_sy;
  logic scl_f;
  logic sda_f;
  logic scl_q;
  logic sda_q;
  logic [3:0] scl_cnt;
  logic [3:0] sda_cnt;
  logic [3:0] bitn;
  logic [7:0] shreg;
  logic ack_phase;
  logic [1:0] sel_sy;
  logic [7:0] ptr;
  logic drive_low;
  logic [7:0] txreg;
  logic buf_full;
  logic [7:0] buf_addr [srasl_pkg::BUF_DEPTH];
  logic [7:0] buf_data [srasl_pkg::BUF_DEPTH];
  logic [1:0] buf_cnt;
  logic buf_wp;
  logic buf_rp;
  logic push;
  logic head_nx;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  ////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers, then spike filter on clock and data only
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      scl_sy <= 2'h3;
      sda_sy <= 2'h3;
      sel_sy <= 2'h0;
    end else begin
      scl_sy <= {scl_sy[0], bus.scl};
      sda_sy <= {sda_sy[0], bus.sda};
      sel_sy <= {sel_sy[0], address_select_bit_i};
    end
  end
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      scl_f <= 1'b1;
      scl_cnt <= 4'h0;
    end else if (scl_sy[1] == scl_f) begin
      scl_cnt <= 4'h0;
    end else if (scl_cnt == 4'(FILT - 1)) begin
      scl_f <= scl_sy[1];
      scl_cnt <= 4'h0;
    end else begin
      scl_cnt <= scl_cnt + 4'h1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      sda_f <= 1'b1;
      sda_cnt <= 4'h0;
    end else if (sda_sy[1] == sda_f) begin
      sda_cnt <= 4'h0;
    end else if (sda_cnt == 4'(FILT - 1)) begin
      sda_f <= sda_sy[1];
      sda_cnt <= 4'h0;
    end else begin
      sda_cnt <= sda_cnt + 4'h1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end
  assign scl_rise = scl_f && !scl_q;
  assign scl_fall = !scl_f && scl_q;
  assign start_c = scl_f && scl_q && sda_q && !sda_f;
  assign stop_c = scl_f && scl_q && !sda_q && sda_f;
  ////////////////////////////////////////////////////////////////////////
  // byte engine
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state <= S_IDLE;
      bitn <= 4'h0;
      shreg <= 8'h00;
      ack_phase <= 1'b0;
      ptr <= srasl_pkg::PTR_RESET;
      drive_low <= 1'b0;
      txreg <= 8'h00;
      push <= 1'b0;
    end else begin
      push <= 1'b0;
      if (stop_c) begin
        state <= S_IDLE;
        drive_low <= 1'b0;
      end else if (start_c) begin
        state <= S_ADDR;
        bitn <= 4'h0;
        ack_phase <= 1'b0;
        drive_low <= 1'b0;
      end else if (scl_rise && state != S_IDLE && state != S_SKIP) begin
        if (!ack_phase) begin
          shreg <= {shreg[6:0], sda_f};
          bitn <= bitn + 4'h1;
        end else if (state == S_MACK) begin
          // master nack ends reading until next start
          if (sda_f) begin
            state <= S_SKIP;
          end else begin
            state <= S_RDATA;
          end
        end
      end else if (scl_fall) begin
        if (ack_phase) begin
          ack_phase <= 1'b0;
          bitn <= 4'h0;
          if (state == S_RDATA) begin
            txreg <= {rd_data_i[6:0], 1'b0};
            drive_low <= !rd_data_i[7];
          end else begin
            drive_low <= 1'b0;
          end
        end else if (bitn == 4'h8) begin
          ack_phase <= 1'b1;
          unique case (state)
            S_ADDR: begin
              if (shreg[7:2] == srasl_pkg::DEV_ADDR_HI &&
                  shreg[1] == sel_sy[1]) begin
                drive_low <= 1'b1;
                state <= shreg[0] ? S_RDATA : S_REG;
              end else begin
                state <= S_SKIP;
              end
            end
            S_REG: begin
              ptr <= shreg;
              drive_low <= 1'b1;
              state <= S_WDATA;
            end
            S_WDATA: begin
              if (!buf_full) begin
                push <= 1'b1;
                ptr <= ptr + 8'h01;
                drive_low <= 1'b1;
              end
            end
            S_RDATA: begin
              drive_low <= 1'b0;
              ptr <= ptr + 8'h01;
              state <= S_MACK;
            end
            default: begin
              drive_low <= 1'b0;
            end
          endcase
        end else if (state == S_RDATA && bitn != 4'h0) begin
          drive_low <= !txreg[7];
          txreg <= {txreg[6:0], 1'b0};
        end else begin
          drive_low <= 1'b0;
        end
      end
    end
  end
  // first data bit of a read is set on the address acknowledge fall
  assign rd_addr_o = ptr;
  assign bus.sda_dev_o = 1'b0;
  assign bus.sda_dev_oe = drive_low;
  ////////////////////////////////////////////////////////////////////////
  // two-entry write buffer toward the register file
  assign buf_full = buf_cnt == 2'(srasl_pkg::BUF_DEPTH);
  assign wr_valid_o = buf_cnt != 2'h0;
  // head after this edge; a word written this edge into the head slot is taken directly
  assign head_nx = buf_rp ^ (wr_valid_o && wr_ready_i);
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      buf_cnt <= 2'h0;
      buf_wp <= 1'b0;
      buf_rp <= 1'b0;
    end else begin
      if (push) begin
        buf_addr[buf_wp] <= ptr - 8'h01;
        buf_data[buf_wp] <= shreg;
        buf_wp <= !buf_wp;
      end
      if (wr_valid_o && wr_ready_i) begin
        buf_rp <= !buf_rp;
      end
      buf_cnt <= buf_cnt + 2'(push) - 2'(wr_valid_o && wr_ready_i);
    end
  end
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      wr_addr_o <= 8'h00;
      wr_data_o <= 8'h00;
    end else if (push && buf_wp == head_nx) begin
      wr_addr_o <= ptr - 8'h01;
      wr_data_o <= shreg;
    end else begin
      wr_addr_o <= buf_addr[head_nx];
      wr_data_o <= buf_data[head_nx];
    end
  end
endmodule // srasl_slave

// ---- dv/srasl_assertions.sv ----
`timescale 1ns/1ns
module srasl_assertions (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe,
  input wire logic wr_valid_o,
  input wire logic wr_ready_i,
  input wire logic [7:0] wr_addr_o,
  input wire logic [7:0] wr_data_o,
  input wire logic [7:0] rd_addr_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  //////////////////////////////////////////////////////////////////////////
  AST_DEV_DRIVES_LOW: assert property (
    sda_dev_oe |-> !sda_dev_o && !sda)
    else $error("device drove data high");
  AST_DEV_CHANGE_SCL_LOW: assert property (
    $changed(sda_dev_oe) |-> !scl && !$past(scl))
    else $error("device moved data while clock high");
  AST_IDLE_AFTER_STOP: assert property (
    $rose(sda) && scl && $past(scl) |-> !sda_dev_oe [*8])
    else $error("device drives data after stop");
  AST_START_LISTEN: assert property (
    $fell(sda) && scl && $past(scl) |-> !sda_dev_oe [*8])
    else $error("device drives data after start");
  AST_DATA_STEADY: assert property (
    $rose(scl) |-> $stable(sda) [*4])
    else $error("data moved around clock rise");
  AST_CLOCK_RATE: assert property (
    $rose(scl) |-> scl [*8]) else $error("serial clock high too short");
  AST_WRITE_HOLD: assert property (
    wr_valid_o && $past(wr_valid_o) && !wr_ready_i
    |=> wr_valid_o && $stable(wr_addr_o) && $stable(wr_data_o))
    else $error("write entry changed while stalled");
  AST_POINTER_SCL_LOW: assert property (
    $changed(rd_addr_o) |-> !scl)
    else $error("pointer moved while clock high");
endmodule // srasl_assertions

// ---- dv/test_serial_register_access_slave.sv ----
`timescale 1ns/1ns
module test_serial_register_access_slave;
  logic clk_i, resetn_i, sel_bit, stall;
  logic wr_valid, wr_ready, cmd_valid, cmd_ready, cmd_read;
  logic rsp_valid, rsp_nack;
  logic [6:0] cmd_dev;
  logic [7:0] wr_addr, wr_data, rd_addr, rd_data, cmd_reg, cmd_data;
  logic [7:0] rsp_data, a, d;
  logic [7:0] regs [256];
  logic [15:0] got [$];
  int miscompares, checks_done, cyc;
  srasl_if link();
  srasl_slave u_srasl_slave (.clk_i(clk_i), .resetn_i(resetn_i),
    .bus(link), .address_select_bit_i(sel_bit), .wr_valid_o(wr_valid),
    .wr_ready_i(wr_ready), .wr_addr_o(wr_addr), .wr_data_o(wr_data),
    .rd_addr_o(rd_addr), .rd_data_i(rd_data));
  srasl_master #(.HALF(10)) u_srasl_master (.clk_i(clk_i),
    .resetn_i(resetn_i), .bus(link), .cmd_valid_i(cmd_valid),
    .cmd_ready_o(cmd_ready), .cmd_read_i(cmd_read), .cmd_dev_i(cmd_dev),
    .cmd_reg_i(cmd_reg), .cmd_data_i(cmd_data), .rsp_valid_o(rsp_valid),
    .rsp_data_o(rsp_data), .rsp_nack_o(rsp_nack));
  srasl_assertions chk_link (.clk_i(clk_i), .resetn_i(resetn_i),
    .scl(link.scl), .sda(link.sda), .sda_dev_o(link.sda_dev_o),
    .sda_dev_oe(link.sda_dev_oe), .wr_valid_o(wr_valid),
    .wr_ready_i(wr_ready), .wr_addr_o(wr_addr), .wr_data_o(wr_data),
    .rd_addr_o(rd_addr));
  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // register file beside the slave; unless stalled, ready follows valid by half a cycle,
  // so an entry recorded here is taken at the next rising edge
  always @(negedge clk_i) begin
    if (wr_valid === 1'b1 && stall === 1'b0) begin
      got.push_back({wr_addr, wr_data});
      regs[wr_addr] = wr_data;
    end
    wr_ready <= wr_valid && !stall;
    rd_data <= regs[rd_addr];
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      miscompares++;
      give_verdict();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] seen);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic xfer(input logic rd, input logic [6:0] dev,
                      input logic [7:0] r, input logic [7:0] dt,
                      input logic nk);
    int n;
    @(negedge clk_i);
    cmd_valid = 1'b1;
    cmd_read = rd;
    cmd_dev = dev;
    cmd_reg = r;
    cmd_data = dt;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 4000) begin
      @(negedge clk_i);
      n++;
    end
    @(negedge clk_i);
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 8000) begin
      @(negedge clk_i);
      n++;
    end
    chk("nack flag", {15'h0000, nk}, {15'h0000, rsp_nack});
    if (rd) begin
      chk("read data", {8'h00, dt}, {8'h00, rsp_data});
    end
    while (cmd_ready !== 1'b1 && n < 12000) begin
      @(negedge clk_i);
      n++;
    end
  endtask
  task automatic expect_wr(input logic [7:0] ea, input logic [7:0] ed);
    chk("write entry", {ea, ed},
        got.size() > 0 ? got.pop_front() : 'x);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    resetn_i = 1'b0;
    sel_bit = 1'b0;
    stall = 1'b0;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_dev = 7'h00;
    cmd_reg = 8'h00;
    cmd_data = 8'h00;
    wr_ready = 1'b0;
    rd_data = 8'h00;
    foreach (regs[i]) regs[i] = 8'h00;
    repeat (16) @(negedge clk_i);
    resetn_i = 1'b1;
    for (int s = 0; s < 2; s++) begin
      sel_bit = s[0];
      a = 8'h10 + 8'(s);
      d = 8'hA5 ^ 8'(s);
      xfer(1'b0, {6'h1D, sel_bit}, a, d, 1'b0);
      expect_wr(a, d);
      chk("pointer", {8'h00, a + 8'h01}, {8'h00, rd_addr});
      xfer(1'b1, {6'h1D, sel_bit}, a, d, 1'b0);
      chk("pointer", {8'h00, a + 8'h01}, {8'h00, rd_addr});
    end
    xfer(1'b0, 7'h3A, 8'h40, 8'h77, 1'b1);
    chk("entry count", 16'h0000, 16'(got.size()));
    xfer(1'b0, 7'h3B, 8'hFF, 8'h3C, 1'b0);
    expect_wr(8'hFF, 8'h3C);
    xfer(1'b1, 7'h3B, 8'hFF, 8'h3C, 1'b0);
    chk("pointer", 16'h0000, {8'h00, rd_addr});
    stall = 1'b1;
    xfer(1'b0, 7'h3B, 8'h20, 8'h11, 1'b0);
    xfer(1'b0, 7'h3B, 8'h21, 8'h22, 1'b0);
    xfer(1'b0, 7'h3B, 8'h22, 8'h33, 1'b1);
    chk("pointer", 16'h0022, {8'h00, rd_addr});
    stall = 1'b0;
    for (int n = 0; n < 200 && got.size() < 2; n++) begin
      @(negedge clk_i);
    end
    expect_wr(8'h20, 8'h11);
    expect_wr(8'h21, 8'h22);
    chk("entry count", 16'h0000, 16'(got.size()));
    give_verdict();
  end
endmodule // test_serial_register_access_slave
